// ===== hw/tspl_top.sv
// Purpose: trap status flags and priority level upper bit, AXI4-Lite registers
// Assumes: trap and level inputs are single-cycle pulses from core logic on aclk
// Notes: registers occupy bits 15:0 of each word, upper bits read zero
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tspl_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic trap_divide_zero,
	input wire logic trap_math,
	input wire logic trap_address,
	input wire logic trap_stack,
	input wire logic trap_osc_fail,
	input wire logic core_level_load,
	input wire logic [3:0] core_level_value,
	input wire logic [2:0] pending_level,
	input wire logic pending_valid,
	input wire logic handler_active,
	output logic [3:0] cpu_level,
	output logic nesting_disable,
	output logic take_interrupt,
	output logic irq
);
	typedef struct packed {
		logic aw_full;
		logic [4:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic b_valid;
		logic [1:0] b_resp;
		logic r_valid;
		logic [31:0] r_data;
		logic [1:0] r_resp;
		logic priority_upper_bit;
		logic [2:0] priority_lower_bits;
		logic nesting_disable;
		logic [15:0] trap_flags;
		logic [4:0] irq_status;
		logic [4:0] irq_mask;
	} tspl_state_type;

	tspl_state_type state;
	tspl_state_type next_state;
	logic [4:0] trap_events;
	logic [15:0] wr_val;
	logic do_write;

	function automatic logic [31:0] tspl_read(input logic [4:0] addr, input tspl_state_type s);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (addr)
			tspl_pkg::addr_core_priority_control:
				v[tspl_pkg::pos_priority_upper_bit] = s.priority_upper_bit;
			tspl_pkg::addr_trap_status_control: begin
				v[15:0] = s.trap_flags & tspl_pkg::trap_flag_mask;
				v[tspl_pkg::pos_nesting_disable] = s.nesting_disable;
			end
			tspl_pkg::addr_cpu_status_word:
				v[7:5] = s.priority_lower_bits;
			tspl_pkg::addr_irq_status:
				v[4:0] = s.irq_status;
			tspl_pkg::addr_irq_mask:
				v[4:0] = s.irq_mask;
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic addr_ok(input logic [4:0] addr);
		return addr == tspl_pkg::addr_core_priority_control
			|| addr == tspl_pkg::addr_trap_status_control
			|| addr == tspl_pkg::addr_cpu_status_word
			|| addr == tspl_pkg::addr_irq_status
			|| addr == tspl_pkg::addr_irq_mask;
	endfunction

	assign trap_events = {trap_divide_zero, trap_math, trap_address, trap_stack, trap_osc_fail};
	assign do_write = state.aw_full && state.w_full && !state.b_valid;
	// byte lanes 0 and 1 carry the 16-bit register
	assign wr_val = {state.w_strb[1] ? state.w_data[15:8] : 8'h00,
		state.w_strb[0] ? state.w_data[7:0] : 8'h00};

	always_comb begin
		logic [15:0] keep;
		logic [15:0] flags;
		keep = {{8{state.w_strb[1]}}, {8{state.w_strb[0]}}};
		next_state = state;
		if (s_axi_awvalid && s_axi_awready) begin
			next_state.aw_full = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_state.w_full = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
		end
		if (state.b_valid && s_axi_bready) begin
			next_state.b_valid = 1'b0;
		end
		if (state.r_valid && s_axi_rready) begin
			next_state.r_valid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_state.r_valid = 1'b1;
			next_state.r_data = tspl_read(s_axi_araddr, state);
			next_state.r_resp = addr_ok(s_axi_araddr) ? tspl_pkg::resp_okay : tspl_pkg::resp_slverr;
		end
		// core level update first, software writes act after it
		if (core_level_load) begin
			next_state.priority_upper_bit = core_level_value[3];
			next_state.priority_lower_bits = core_level_value[2:0];
		end
		flags = state.trap_flags;
		if (do_write) begin
			next_state.aw_full = 1'b0;
			next_state.w_full = 1'b0;
			next_state.b_valid = 1'b1;
			next_state.b_resp = addr_ok(state.aw_addr) ? tspl_pkg::resp_okay : tspl_pkg::resp_slverr;
			unique case (state.aw_addr)
				tspl_pkg::addr_core_priority_control:
					// writing zero clears, writing one has no effect
					if (keep[tspl_pkg::pos_priority_upper_bit]
						&& !wr_val[tspl_pkg::pos_priority_upper_bit]) begin
						next_state.priority_upper_bit = 1'b0;
					end
				tspl_pkg::addr_trap_status_control: begin
					flags = (flags & ~(keep & tspl_pkg::trap_flag_mask))
						| (wr_val & keep & tspl_pkg::trap_flag_mask);
					if (keep[tspl_pkg::pos_nesting_disable]) begin
						next_state.nesting_disable = wr_val[tspl_pkg::pos_nesting_disable];
					end
				end
				tspl_pkg::addr_cpu_status_word:
					if (!state.nesting_disable && keep[7]) begin
						next_state.priority_lower_bits = wr_val[7:5];
					end
				tspl_pkg::addr_irq_status:
					next_state.irq_status = state.irq_status & ~wr_val[4:0];
				tspl_pkg::addr_irq_mask:
					if (keep[0]) begin
						next_state.irq_mask = wr_val[4:0] & tspl_pkg::irq_bits_mask;
					end
				default: begin
				end
			endcase
		end
		// trap events win over a clear in the same cycle
		if (trap_divide_zero) flags[tspl_pkg::pos_divide_zero_flag] = 1'b1;
		if (trap_math) flags[tspl_pkg::pos_math_trap_flag] = 1'b1;
		if (trap_address) flags[tspl_pkg::pos_address_trap_flag] = 1'b1;
		if (trap_stack) flags[tspl_pkg::pos_stack_trap_flag] = 1'b1;
		if (trap_osc_fail) flags[tspl_pkg::pos_osc_fail_trap_flag] = 1'b1;
		next_state.trap_flags = flags & tspl_pkg::trap_flag_mask;
		next_state.irq_status = next_state.irq_status | trap_events;
		if (!aresetn) begin
			next_state = '0;
		end
	end

	always_ff @(posedge aclk) begin
		state <= next_state;
	end

	assign s_axi_awready = !state.aw_full;
	assign s_axi_wready = !state.w_full;
	assign s_axi_bvalid = state.b_valid;
	assign s_axi_bresp = state.b_resp;
	assign s_axi_arready = !state.r_valid;
	assign s_axi_rvalid = state.r_valid;
	assign s_axi_rdata = state.r_data;
	assign s_axi_rresp = state.r_resp;
	assign cpu_level = {state.priority_upper_bit, state.priority_lower_bits};
	assign nesting_disable = state.nesting_disable;
	assign irq = |(state.irq_status & state.irq_mask);

	tspl_arbiter u_arbiter (
		.cpu_level(cpu_level),
		.pending_level(pending_level),
		.pending_valid(pending_valid),
		.handler_active(handler_active),
		.nesting_disable(state.nesting_disable),
		.take_interrupt(take_interrupt)
	);
endmodule // tspl_top
`default_nettype wire

// ===== hw/tspl_pkg.sv
// Purpose: shared constants for the trap status and priority level block
// Assumes: 32-bit AXI4-Lite data, 16-bit registers in the low half of a word
// Notes: offsets are byte addresses
package tspl_pkg;
	// five address bits so that the mask register at 0x10 does not alias offset 0
	localparam logic [4:0] addr_core_priority_control = 5'h00;
	localparam logic [4:0] addr_trap_status_control = 5'h04;
	localparam logic [4:0] addr_cpu_status_word = 5'h08;
	localparam logic [4:0] addr_irq_status = 5'h0c;
	localparam logic [4:0] addr_irq_mask = 5'h10;
	localparam int reg_width = 16;
	localparam int pos_priority_upper_bit = 3;
	localparam int pos_nesting_disable = 15;
	localparam int pos_divide_zero_flag = 6;
	localparam int pos_math_trap_flag = 4;
	localparam int pos_address_trap_flag = 3;
	localparam int pos_stack_trap_flag = 2;
	localparam int pos_osc_fail_trap_flag = 1;
	localparam int pos_lower_lo = 5;
	localparam logic [15:0] trap_flag_mask = 16'h005e;
	localparam logic [15:0] trap_ctl_write_mask = 16'h805e;
	localparam logic [15:0] status_lower_mask = 16'h00e0;
	localparam logic [2:0] max_lower_level = 3'h7;
	localparam logic [4:0] irq_bits_mask = 5'h1f;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
endpackage : tspl_pkg

// ===== hw/tspl_arbiter.sv
// Purpose: decides whether a pending user interrupt may be taken
// Assumes: pending level and running state come from core logic on aclk
// Notes: purely combinational, traps are never gated here
`timescale 1ns/1ps
`default_nettype none
module tspl_arbiter (
	input wire logic [3:0] cpu_level,
	input wire logic [2:0] pending_level,
	input wire logic pending_valid,
	input wire logic handler_active,
	input wire logic nesting_disable,
	output logic take_interrupt
);
	always_comb begin
		take_interrupt = 1'b0;
		// upper level bit blocks every user source
		if (pending_valid && !cpu_level[3]) begin
			if (handler_active && nesting_disable) begin
				take_interrupt = 1'b0;
			end else begin
				take_interrupt = pending_level > cpu_level[2:0];
			end
		end
	end
endmodule // tspl_arbiter
`default_nettype wire

// ===== tb/tspl_sva.sv
// Purpose: port checks for tspl_top
// Assumes: one clock, sync reset
// Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module tspl_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic core_level_load,
	input wire logic [2:0] pending_level,
	input wire logic pending_valid,
	input wire logic handler_active,
	input wire logic [3:0] cpu_level,
	input wire logic nesting_disable,
	input wire logic take_interrupt,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	upper_blocks_a: assert property (cpu_level[3] |-> !take_interrupt)
		else $error("user take at upper level");
	nest_hold_a: assert property (handler_active && nesting_disable |-> !take_interrupt)
		else $error("preempt while nesting off");
	take_grant_a: assert property (pending_valid && !cpu_level[3] &&
		!(handler_active && nesting_disable) && pending_level > cpu_level[2:0] |-> take_interrupt)
		else $error("higher level not taken");
	upper_stay_a: assert property (!cpu_level[3] && !core_level_load |=> !cpu_level[3])
		else $error("upper bit raised");
	lower_frozen_a: assert property (nesting_disable && !core_level_load |=>
		$stable(cpu_level[2:0])) else $error("lower bits moved");
	rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read lanes not zero");
	rvalid_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	irq_sticky_a: assert property (irq |=> irq || s_axi_bvalid)
		else $error("irq dropped without write");
	cover property (take_interrupt);
	cover property (cpu_level[3]);
	cover property (irq);
endmodule // tspl_sva
bind tspl_top tspl_sva u_sva (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .core_level_load, .pending_level, .pending_valid,
	.handler_active, .cpu_level, .nesting_disable, .take_interrupt, .irq);
`default_nettype wire

// ===== tb/tspl_core_model.sv
// Purpose: core side raising trap events
// Assumes: requests come from the bench on aclk
// Notes: one request, one single-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module tspl_core_model (
	input wire logic aclk,
	input wire logic [4:0] fire,
	output logic [4:0] trap
);
	// pulses, never held, so flag stickiness is really exercised
	always_ff @(posedge aclk) trap <= fire;
endmodule // tspl_core_model
`default_nettype wire

// ===== tb/tspl_bench.sv
// Purpose: self-checking bench for tspl_top
// Assumes: AXI4-Lite master, one transfer at a time
// Notes: bus results checked against a queue
`timescale 1ns/1ps
`default_nettype none
module tspl_bench;
	logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0, core_level_load = '0, pending_valid = '0;
	logic handler_active = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, trap_divide_zero, trap_math, trap_address, trap_stack, trap_osc_fail;
	logic nesting_disable, take_interrupt, irq;
	logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [3:0] s_axi_wstrb = 4'hf, core_level_value = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, pending_level = '0, lo;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] cpu_level;
	logic [4:0] fire = '0;
	logic [15:0] seed = 16'hb89d;
	logic [33:0] exp_q[$];
	int n_errors = 0, checked = 0;
	int pos[5] = '{6, 4, 3, 2, 1};
	tspl_top DUT (.*);
	tspl_core_model u_core (.aclk, .fire,
		.trap({trap_divide_zero, trap_math, trap_address, trap_stack, trap_osc_fail}));
	always #12.5 aclk = ~aclk;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [33:0] seen, input logic [33:0] want);
		checked++;
		if (seen !== want) begin
			n_errors++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic print_verdict;
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, 32'h0000_0000});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		while (!s_axi_rvalid) @(posedge aclk);
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0000_0000}, exp_q.pop_front());
	end
	initial begin
		repeat (5000) @(posedge aclk);
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(tspl_pkg::addr_core_priority_control, '0);
		rd(tspl_pkg::addr_trap_status_control, '0);
		wr(tspl_pkg::addr_trap_status_control, 32'hffff_ffff, 2'h0);
		rd(tspl_pkg::addr_trap_status_control, 34'h0_0000_805e);
		wr(tspl_pkg::addr_core_priority_control, 32'hffff_ffff, 2'h0);
		rd(tspl_pkg::addr_core_priority_control, '0);
		rd(5'h02, {tspl_pkg::resp_slverr, 32'h0000_0000});
		rd(tspl_pkg::addr_irq_mask, '0);
		for (int i = 0; i < 5; i++) begin
			wr(tspl_pkg::addr_trap_status_control, '0, 2'h0);
			wr(tspl_pkg::addr_irq_status, 32'h0000_001f, 2'h0);
			wr(tspl_pkg::addr_irq_mask, i[0] ? '0 : 32'h0000_001f, 2'h0);
			fire <= 5'h10 >> i;
			@(posedge aclk);
			fire <= '0;
			repeat (3) @(posedge aclk);
			chk(irq, !i[0]);
			rd(tspl_pkg::addr_trap_status_control, 34'h1 << pos[i]);
			rd(tspl_pkg::addr_irq_status, 34'h10 >> i);
		end
		for (int k = 0; k < 12; k++) begin
			seed = lfsr(seed);
			wr(tspl_pkg::addr_trap_status_control, {16'h0000, seed[15], 15'h0000}, 2'h0);
			core_level_value <= seed[3:0];
			core_level_load <= 1'h1;
			pending_level <= seed[6:4];
			pending_valid <= seed[7];
			handler_active <= seed[8];
			@(posedge aclk);
			core_level_load <= 1'h0;
			wr(tspl_pkg::addr_cpu_status_word, 32'h0000_00e0, 2'h0);
			lo = seed[15] ? seed[2:0] : 3'h7;
			rd(tspl_pkg::addr_core_priority_control, {30'h0, seed[3], 3'h0});
			rd(tspl_pkg::addr_cpu_status_word, {26'h0, lo, 5'h0});
			chk(take_interrupt, seed[7] && !seed[3] && !(seed[8] && seed[15]) && seed[6:4] > lo);
			wr(tspl_pkg::addr_core_priority_control, '0, 2'h0);
			chk(cpu_level, {1'h0, lo});
		end
		print_verdict();
	end
endmodule // tspl_bench
`default_nettype wire
